// ===== common/jcs_pkg.sv
// Shared constants and types for the test-port configuration loader.
package jcs_pkg;

  // ==========================================================================
  // Instruction opcodes, six bits wide.
  localparam int IR_W = 6;
  localparam logic [5:0] OP_CFG_LOAD = 6'h05;
  localparam logic [5:0] OP_STARTUP = 6'h0C;
  localparam logic [5:0] OP_ISC_SHUTDOWN = 6'h10;
  localparam logic [5:0] OP_ISC_FINISH = 6'h16;
  localparam logic [5:0] OP_BYPASS = 6'h3F;
  localparam logic [5:0] IR_RESET_VAL = 6'h01;

  // ==========================================================================
  // Sequence lengths.
  localparam int RESET_TMS_CLOCKS = 5;
  localparam int STARTUP_MIN_CLOCKS = 16;
  localparam int EXIT_TMS_CLOCKS = 3;
  localparam logic [3:0] SEQ_STEPS = 4'h8;

  // ==========================================================================
  // Link timing: the host divides ref_clk by 2*TCK_HALF for the test clock.
  localparam int REF_CLK_NS = 50;
  localparam int TCK_PERIOD_NS = 400;
  localparam int TCK_HALF = TCK_PERIOD_NS / (2 * REF_CLK_NS);

  // ==========================================================================
  // Configuration word handed to the fabric.
  localparam int CFG_W = 16;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jcs_tap_t;

  // Next TAP state from the current state and TMS.
  function automatic jcs_tap_t jcs_tap_next(input jcs_tap_t s,
                                            input logic tms);
    case (s)
      TAP_RESET: jcs_tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: jcs_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: jcs_tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: jcs_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: jcs_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: jcs_tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: jcs_tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: jcs_tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: jcs_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: jcs_tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: jcs_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: jcs_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: jcs_tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: jcs_tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: jcs_tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: jcs_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default: jcs_tap_next = TAP_RESET;
    endcase
  endfunction

endpackage

// ===== common/jcs_link_if.sv
// Test-port link between the configuration host and the device.
`timescale 1ns/100ps
`default_nettype none
interface jcs_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;

  modport host (output tck, output tms, output tdi, input tdo);
  modport dev (input tck, input tms, input tdi, output tdo);
endinterface
`default_nettype wire

// ===== hdl/jcs_device.sv
// Device end: TAP, instruction decode, configuration path, startup/shutdown.
`timescale 1ns/100ps
`default_nettype none
module jcs_device (
  input wire logic ref_clk,
  input wire logic nrst,
  jcs_link_if.dev link,
  input wire logic reprogram_n,
  output logic [jcs_pkg::CFG_W-1:0] cfg_word,
  output logic cfg_word_valid,
  output logic [3:0] seq_step,
  output logic operational,
  output logic insystem_access_state
);
  import jcs_pkg::*;

  // ==========================================================================
  // Pin synchronisers. Every link pin passes two flops before use.
  logic [1:0] tck_s_q, tck_s_d;
  logic [1:0] tms_s_q, tms_s_d;
  logic [1:0] tdi_s_q, tdi_s_d;
  logic [1:0] rpg_s_q, rpg_s_d;
  logic tck_prev_q, tck_prev_d;

  // Shift in the raw pins; only bit 1 of each pair is read elsewhere.
  always_comb begin
    tck_s_d = {tck_s_q[0], link.tck};
    tms_s_d = {tms_s_q[0], link.tms};
    tdi_s_d = {tdi_s_q[0], link.tdi};
    rpg_s_d = {rpg_s_q[0], reprogram_n};
    tck_prev_d = tck_s_q[1];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tck_s_q <= 2'h0;
      tms_s_q <= 2'h3;
      tdi_s_q <= 2'h0;
      rpg_s_q <= 2'h3;
      tck_prev_q <= 1'b0;
    end else begin
      tck_s_q <= tck_s_d;
      tms_s_q <= tms_s_d;
      tdi_s_q <= tdi_s_d;
      rpg_s_q <= rpg_s_d;
      tck_prev_q <= tck_prev_d;
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic tms_i;
  logic tdi_i;
  assign tck_rise = tck_s_q[1] & ~tck_prev_q;
  assign tck_fall = ~tck_s_q[1] & tck_prev_q;
  assign tms_i = tms_s_q[1];
  assign tdi_i = tdi_s_q[1];

  // ==========================================================================
  // TAP, shift registers and sequencer state.
  jcs_tap_t tap_q, tap_d;
  logic [IR_W-1:0] ir_sh_q, ir_sh_d;
  logic [IR_W-1:0] ir_q, ir_d;
  logic [CFG_W-1:0] cfg_sh_q, cfg_sh_d;
  logic [CFG_W-1:0] cfg_word_q, cfg_word_d;
  logic cfg_valid_q, cfg_valid_d;
  logic byp_q, byp_d;
  logic tdo_q, tdo_d;
  logic [3:0] step_q, step_d;
  logic oper_q, oper_d;
  logic isc_q, isc_d;
  logic cfg_armed_q, cfg_armed_d;

  // The whole TAP advances on the synchronised test-clock rising edge, so
  // startup and shutdown are stepped from the test clock; a reprogram pulse clears them on any ref_clk cycle.
  always_comb begin
    tap_d = tap_q;
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    cfg_sh_d = cfg_sh_q;
    cfg_word_d = cfg_word_q;
    cfg_valid_d = 1'b0;
    byp_d = byp_q;
    tdo_d = tdo_q;
    step_d = step_q;
    oper_d = oper_q;
    isc_d = isc_q;
    cfg_armed_d = cfg_armed_q;
    // A full-reprogram pulse clears the fabric and allows a new load.
    if (!rpg_s_q[1]) begin
      oper_d = 1'b0;
      isc_d = 1'b0;
      step_d = 4'h0;
      cfg_armed_d = 1'b1;
    end
    if (tck_rise) begin
      tap_d = jcs_tap_next(tap_q, tms_i);
      // Reaching reset after full startup: the device runs. The host stops
      // the test clock there, so this must not wait for a clock in reset.
      // The load path then closes until a reprogram or shutdown.
      if (tap_d == TAP_RESET && step_q == SEQ_STEPS && !isc_q) begin
        oper_d = 1'b1;
        cfg_armed_d = 1'b0;
      end
      case (tap_q)
        TAP_RESET: ir_d = IR_RESET_VAL;
        TAP_CAP_IR: ir_sh_d = {oper_q, isc_q, 2'h0, 2'h1};
        // Opcode enters at the top and moves down: LSB arrives first.
        TAP_SHIFT_IR: ir_sh_d = {tdi_i, ir_sh_q[IR_W-1:1]};
        TAP_CAP_DR: byp_d = 1'b0;
        TAP_SHIFT_DR: begin
          byp_d = tdi_i;
          // Bits enter at the right and move left, MSB first; the last one
          // is taken on the edge that moves into exit1-DR.
          if (ir_q == OP_CFG_LOAD && cfg_armed_q)
            cfg_sh_d = {cfg_sh_q[CFG_W-2:0], tdi_i};
        end
        TAP_UPD_DR: begin
          if (ir_q == OP_CFG_LOAD && cfg_armed_q) begin
            cfg_word_d = cfg_sh_q;
            cfg_valid_d = 1'b1;
          end
        end
        TAP_UPD_IR: begin
          ir_d = ir_sh_q;
          // The startup trigger and in-system finish set up startup.
          if (ir_sh_q == OP_STARTUP || ir_sh_q == OP_ISC_FINISH)
            step_d = 4'h0;
          if (ir_sh_q == OP_ISC_SHUTDOWN && oper_q) begin
            isc_d = 1'b1;
            step_d = SEQ_STEPS;
          end
        end
        TAP_IDLE: begin
          // Startup steps upward once per idle clock.
          if ((ir_q == OP_STARTUP && !isc_q) ||
              (ir_q == OP_ISC_FINISH && isc_q)) begin
            if (step_q != SEQ_STEPS)
              step_d = step_q + 4'h1;
            else if (ir_q == OP_ISC_FINISH)
              isc_d = 1'b0;
          end
          // Shutdown walks the same steps downward.
          if (ir_q == OP_ISC_SHUTDOWN && isc_q) begin
            oper_d = 1'b0;
            if (step_q != 4'h0)
              step_d = step_q - 4'h1;
            else
              cfg_armed_d = 1'b1;
          end
          if (ir_q == OP_CFG_LOAD)
            cfg_armed_d = ~oper_q | cfg_armed_q;
        end
        default: begin
        end
      endcase
    end
    // TDO changes on the falling test clock, as the port expects.
    if (tck_fall) begin
      if (tap_q == TAP_SHIFT_IR)
        tdo_d = ir_sh_q[0];
      else if (tap_q == TAP_SHIFT_DR)
        tdo_d = (ir_q == OP_CFG_LOAD) ? cfg_sh_q[CFG_W-1] : byp_q;
      else
        tdo_d = 1'b0;
    end
  end

  // Registering only; reset leaves the device unconfigured.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tap_q <= TAP_RESET;
      ir_sh_q <= IR_RESET_VAL;
      ir_q <= IR_RESET_VAL;
      cfg_sh_q <= '0;
      cfg_word_q <= '0;
      cfg_valid_q <= 1'b0;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
      step_q <= 4'h0;
      oper_q <= 1'b0;
      isc_q <= 1'b0;
      cfg_armed_q <= 1'b1;
    end else begin
      tap_q <= tap_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      cfg_sh_q <= cfg_sh_d;
      cfg_word_q <= cfg_word_d;
      cfg_valid_q <= cfg_valid_d;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
      step_q <= step_d;
      oper_q <= oper_d;
      isc_q <= isc_d;
      cfg_armed_q <= cfg_armed_d;
    end
  end

  assign link.tdo = tdo_q;
  assign cfg_word = cfg_word_q;
  assign cfg_word_valid = cfg_valid_q;
  assign seq_step = step_q;
  assign operational = oper_q;
  assign insystem_access_state = isc_q;

endmodule
`default_nettype wire

// ===== hdl/jcs_host.sv
// Host end: drives the TAP through a full configuration load and startup.
`timescale 1ns/100ps
`default_nettype none
module jcs_host (
  input wire logic ref_clk,
  input wire logic nrst,
  jcs_link_if.host link,
  input wire logic start,
  input wire logic [jcs_pkg::CFG_W-1:0] bitstream,
  output logic busy,
  output logic done
);
  import jcs_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE, H_RESET, H_TO_IR, H_IR, H_TO_DR, H_DR, H_BACK_IR, H_IR2,
    H_RUN, H_EXIT
  } jcs_hst_t;

  // ==========================================================================
  // Each step is a list of TMS levels; cnt counts test clocks in a step.
  jcs_hst_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] div_q, div_d;
  logic tck_q, tck_d;
  logic tms_q, tms_d;
  logic tdi_q, tdi_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [CFG_W-1:0] data_q, data_d;

  // Test-clock divider; work happens on the falling edge so TMS and TDI
  // settle half a period before the device samples on the rising edge.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    div_d = div_q;
    tck_d = tck_q;
    tms_d = tms_q;
    tdi_d = tdi_q;
    busy_d = busy_q;
    done_d = 1'b0;
    data_d = data_q;
    if (st_q == H_IDLE) begin
      tck_d = 1'b0;
      div_d = 3'h0;
      if (start) begin
        st_d = H_RESET;
        cnt_d = 5'h0;
        busy_d = 1'b1;
        data_d = bitstream;
        tms_d = 1'b1;
      end
    end else if (div_q == 3'(TCK_HALF - 1)) begin
      div_d = 3'h0;
      tck_d = ~tck_q;
      if (tck_q) begin
        cnt_d = cnt_q + 5'h1;
        case (st_q)
          H_RESET: if (cnt_q == 5'(RESET_TMS_CLOCKS - 1)) begin
            st_d = H_TO_IR;
            cnt_d = 5'h0;
          end
          // Idle one, select two, capture and shift-IR two.
          H_TO_IR: if (cnt_q == 5'h4) begin
            st_d = H_IR;
            cnt_d = 5'h0;
          end
          // Update-DR and idle first, then the same walk to shift-IR.
          H_BACK_IR: if (cnt_q == 5'h5) begin
            st_d = H_IR2;
            cnt_d = 5'h0;
          end
          H_IR, H_IR2: if (cnt_q == 5'(IR_W - 1)) begin
            st_d = (st_q == H_IR) ? H_TO_DR : H_RUN;
            cnt_d = 5'h0;
          end
          H_TO_DR: if (cnt_q == 5'h3) begin
            st_d = H_DR;
            cnt_d = 5'h0;
          end
          H_DR: begin
            data_d = {data_q[CFG_W-2:0], 1'b0};
            if (cnt_q == 5'(CFG_W - 1)) begin
              st_d = H_BACK_IR;
              cnt_d = 5'h0;
            end
          end
          // Update-IR then the startup clocks in idle.
          H_RUN: if (cnt_q == 5'(STARTUP_MIN_CLOCKS)) begin
            st_d = H_EXIT;
            cnt_d = 5'h0;
          end
          H_EXIT: if (cnt_q == 5'(EXIT_TMS_CLOCKS - 1)) begin
            st_d = H_IDLE;
            busy_d = 1'b0;
            done_d = 1'b1;
          end
          default: st_d = H_IDLE;
        endcase
      end
    end else begin
      div_d = div_q + 3'h1;
    end
    // Pin levels for the coming test clock follow state and count.
    if (st_d != st_q || (tck_q && div_q == 3'(TCK_HALF - 1))) begin
      case (st_d)
        H_RESET, H_EXIT: tms_d = 1'b1;
        H_TO_IR: tms_d = (cnt_d == 5'h1 || cnt_d == 5'h2);
        H_BACK_IR:
          tms_d = (cnt_d == 5'h0 || cnt_d == 5'h2 || cnt_d == 5'h3);
        // Opcode LSB first; last bit under TMS high.
        H_IR, H_IR2: begin
          tms_d = (cnt_d == 5'(IR_W - 1));
          tdi_d = (st_d == H_IR) ? OP_CFG_LOAD[cnt_d[2:0]]
                                 : OP_STARTUP[cnt_d[2:0]];
        end
        H_TO_DR: tms_d = (cnt_d < 5'h2);
        // MSB first; the last bit under TMS high.
        H_DR: begin
          tms_d = (cnt_d == 5'(CFG_W - 1));
          tdi_d = data_d[CFG_W-1];
        end
        H_RUN: tms_d = (cnt_d == 5'h0);
        default: tms_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= H_IDLE;
      cnt_q <= 5'h0;
      div_q <= 3'h0;
      tck_q <= 1'b0;
      tms_q <= 1'b1;
      tdi_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      data_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      tck_q <= tck_d;
      tms_q <= tms_d;
      tdi_q <= tdi_d;
      busy_q <= busy_d;
      done_q <= done_d;
      data_q <= data_d;
    end
  end

  assign link.tck = tck_q;
  assign link.tms = tms_q;
  assign link.tdi = tdi_q;
  assign busy = busy_q;
  assign done = done_q;

endmodule
`default_nettype wire

// ===== verification/jcs_link_props.sv
// Link checker for the host-driven test port.
`timescale 1ns/100ps
`default_nettype none
module jcs_link_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi
);
  import jcs_pkg::*;
  jcs_tap_t tap_q, tap_d;
  logic tck_q, rise;
  logic [2:0] rc_q, rc_d;
  logic [5:0] ir_q, ir_d, irn_q, irn_d, drn_q, drn_d, idl_q, idl_d;
  // ==========================================================================
  // Shadow TAP, stepped on the sampled rising edge of the test clock.
  assign rise = tck & ~tck_q;
  always_comb begin
    tap_d = tap_q;
    rc_d = rc_q;
    ir_d = ir_q;
    irn_d = irn_q;
    drn_d = drn_q;
    idl_d = idl_q;
    if (rise) begin
      tap_d = jcs_tap_next(tap_q, tms);
      if (rc_q < 3'h5) rc_d = rc_q + 3'h1;
      // A reset walk forgets the last opcode, so a new run starts clean.
      if (tap_q == TAP_RESET) ir_d = 6'h00;
      if (tap_q == TAP_CAP_IR) begin
        irn_d = 6'h00;
        idl_d = 6'h00;
      end
      if (tap_q == TAP_SHIFT_IR) begin
        ir_d = {tdi, ir_q[5:1]};
        irn_d = irn_q + 6'h01;
      end
      if (tap_q == TAP_CAP_DR) drn_d = 6'h00;
      if (tap_q == TAP_SHIFT_DR) drn_d = drn_q + 6'h01;
      // Saturate so a long idle stretch never wraps below the minimum.
      if (!tms && (tap_q == TAP_UPD_IR || tap_q == TAP_IDLE) &&
          idl_q != 6'h3F) idl_d = idl_q + 6'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tap_q <= TAP_RESET;
      {tck_q, rc_q, ir_q, irn_q, drn_q, idl_q} <= '0;
    end else begin
      tap_q <= tap_d;
      {tck_q, rc_q, ir_q, irn_q, drn_q, idl_q} <=
        {tck, rc_d, ir_d, irn_d, drn_d, idl_d};
    end
  end
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence tck_high_phase;
    tck [*4] ##1 !tck;
  endsequence
  a_tck_half_period: assert property ($rose(tck) |-> tck_high_phase)
    else $error("test clock high phase is not four cycles");
  a_tms_held_high: assert property (tck && $past(tck) |->
    $stable(tms) && $stable(tdi))
    else $error("tms or tdi moved while the test clock was high");
  a_five_reset_clocks: assert property (
    rise && rc_q < 3'h5 |-> tms)
    else $error("tms low during the opening reset clocks");
  a_capir_goes_shift: assert property (
    rise && tap_q == TAP_CAP_IR |-> !tms)
    else $error("host skipped shift-IR");
  a_opcode_six_bits: assert property (
    rise && tap_q == TAP_UPD_IR |-> irn_q == 6'h06 &&
    (ir_q == OP_CFG_LOAD || ir_q == OP_STARTUP))
    else $error("instruction scan was not a six-bit load opcode");
  a_updir_next_step: assert property (
    rise && tap_q == TAP_UPD_IR |-> tms == (ir_q == OP_CFG_LOAD))
    else $error("wrong exit from update-IR");
  a_dr_word_length: assert property (
    rise && tap_q == TAP_UPD_DR |-> drn_q == 6'(CFG_W))
    else $error("bitstream scan has the wrong length");
  a_upddr_to_idle: assert property (
    rise && tap_q == TAP_UPD_DR |-> !tms)
    else $error("host did not return to idle after update-DR");
  a_startup_idle_min: assert property (
    rise && tap_q == TAP_IDLE && tms && ir_q == OP_STARTUP |->
    idl_q >= 6'(STARTUP_MIN_CLOCKS))
    else $error("too few idle clocks under the startup opcode");
  a_exit_to_reset: assert property (
    rise && tap_q inside {TAP_SEL_DR, TAP_SEL_IR} &&
    ir_q == OP_STARTUP |-> tms)
    else $error("host left the reset walk after startup");
endmodule
`default_nettype wire

// ===== verification/jtag_config_sequence_tb.sv
// Bench: host and device joined, plus a bench-driven second device.
`timescale 1ns/100ps
`default_nettype none
module jtag_config_sequence_tb;
  import jcs_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic reprogram_n = 1'b1;
  logic [CFG_W-1:0] bitstream = 16'h0000;
  logic busy, done, vld, vld2, op, op2, isa, isa2;
  logic [CFG_W-1:0] cw, cw2;
  logic [3:0] st, st2;
  logic tdo_s;
  logic [5:0] ir_cap;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int vseen = 0;
  jcs_link_if link ();
  jcs_link_if link2 ();
  jcs_host jcs_host_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .start(start), .bitstream(bitstream), .busy(busy), .done(done));
  jcs_device jcs_device_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .reprogram_n(reprogram_n), .cfg_word(cw), .cfg_word_valid(vld),
    .seq_step(st), .operational(op), .insystem_access_state(isa));
  jcs_device jcs_device2_inst (.ref_clk(ref_clk), .nrst(nrst),
    .link(link2), .reprogram_n(reprogram_n), .cfg_word(cw2),
    .cfg_word_valid(vld2), .seq_step(st2), .operational(op2),
    .insystem_access_state(isa2));
  jcs_link_props jcs_link_props_inst (.ref_clk(ref_clk), .nrst(nrst),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi));
  // ==========================================================================
  // Clock, pulse counter and hang guard.
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (vld === 1'b1) vseen = vseen + 1;
    // A full run takes under 4000 cycles, so this only trips on a hang.
    if (cycles == 12000) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end
  // ==========================================================================
  // Compare tasks.
  task automatic check_word(input logic [CFG_W-1:0] g, e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: word %h, want %h", $time, g, e);
    end
  endtask
  task automatic check_step(input logic [3:0] g, e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: step %h, want %h", $time, g, e);
    end
  endtask
  task automatic check_flag(input logic g, e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: flag %b, want %b", $time, g, e);
    end
  endtask
  // ==========================================================================
  // Host run; poke raises start again mid-run, which must be ignored.
  task automatic run_host(input logic [CFG_W-1:0] bs, input logic poke);
    int i;
    @(negedge ref_clk);
    bitstream = bs;
    start = 1'b1;
    i = 0;
    while (done !== 1'b1 && i < 4000) begin
      @(negedge ref_clk);
      start = poke && i == 100;
      if (poke && i == 100) bitstream = ~bs;
      i++;
    end
    check_flag(done, 1'b1);
    repeat (8) @(negedge ref_clk);
  endtask
  // One test clock on the second link, 400 ns, tms and tdi set while low.
  task automatic clk2(input logic m, d);
    link2.tms = m;
    link2.tdi = d;
    repeat (4) @(negedge ref_clk);
    tdo_s = link2.tdo;
    link2.tck = 1'b1;
    repeat (4) @(negedge ref_clk);
    link2.tck = 1'b0;
  endtask
  // Don't-care data toggles so a stale value is never mistaken for data.
  task automatic hop(input logic m, input int n);
    repeat (n) clk2(m, ~link2.tdi);
  endtask
  task automatic load_ir2(input logic [5:0] opc);
    hop(1'b1, 2);
    hop(1'b0, 2);
    for (int k = 0; k < 6; k++) begin
      clk2(k == 5, opc[k]);
      ir_cap[k] = tdo_s;
    end
    hop(1'b1, 1);
    hop(1'b0, 1);
  endtask
  task automatic load_dr2(input logic [CFG_W-1:0] w);
    hop(1'b1, 1);
    hop(1'b0, 2);
    for (int k = CFG_W - 1; k >= 0; k--) clk2(k == 0, w[k]);
    hop(1'b1, 1);
    hop(1'b0, 1);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    link2.tck = 1'b0;
    link2.tms = 1'b1;
    link2.tdi = 1'b0;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    run_host(16'h8001, 1'b1);
    check_word(cw, 16'h8001);
    check_flag(vseen == 1, 1'b1);
    check_step(st, SEQ_STEPS);
    check_flag(op, 1'b1);
    check_flag(busy, 1'b0);
    check_flag(isa, 1'b0);
    $display("test host_load done");
    run_host(16'h1234, 1'b0);
    check_word(cw, 16'h8001);
    reprogram_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    reprogram_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_flag(op, 1'b0);
    run_host(16'h1234, 1'b0);
    check_word(cw, 16'h1234);
    check_flag(op, 1'b1);
    $display("test reprogram done");
    hop(1'b1, 5);
    hop(1'b0, 1);
    load_ir2(OP_CFG_LOAD);
    check_word(16'(ir_cap), 16'h0001);
    load_dr2(16'hC3A5);
    check_word(cw2, 16'hC3A5);
    load_ir2(OP_STARTUP);
    hop(1'b0, 3);
    check_flag(st2 > 4'h0 && st2 < SEQ_STEPS, 1'b1);
    check_flag(op2, 1'b0);
    hop(1'b0, 12);
    hop(1'b1, 3);
    check_step(st2, SEQ_STEPS);
    check_flag(op2, 1'b1);
    hop(1'b0, 1);
    load_ir2(OP_ISC_SHUTDOWN);
    check_word(16'(ir_cap), 16'h0021);
    check_flag(isa2, 1'b1);
    hop(1'b0, 3);
    check_flag(st2 > 4'h0 && st2 < SEQ_STEPS, 1'b1);
    hop(1'b0, 10);
    check_step(st2, 4'h0);
    check_flag(op2, 1'b0);
    load_ir2(OP_CFG_LOAD);
    load_dr2(16'h5AC3);
    check_word(cw2, 16'h5AC3);
    load_ir2(OP_ISC_FINISH);
    check_word(16'(ir_cap), 16'h0011);
    hop(1'b0, 3);
    check_flag(st2 > 4'h0 && st2 < SEQ_STEPS, 1'b1);
    hop(1'b0, 10);
    check_step(st2, SEQ_STEPS);
    check_flag(isa2, 1'b0);
    $display("test insystem done");
    close_out();
  end
endmodule
`default_nettype wire
